// ==== rtl/ifc_flag_edge_ctrl.sv ====
// interrupt flag registers, external edge detection and vector select control
`timescale 1ns/1ps
module ifc_flag_edge_ctrl #(
   parameter int SYNC_STAGES = 2
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst_b,
   input  wire ifc_pkg::ifc_bus_t             bus,
   output logic      [ifc_pkg::DATA_W-1:0]    rdData,
   input  wire logic [ifc_pkg::DATA_W-1:0]    srcEvents0,
   input  wire logic [ifc_pkg::DATA_W-1:0]    srcEvents1,
   input  wire logic [ifc_pkg::DATA_W-1:0]    srcEvents2,
   input  wire logic [ifc_pkg::DATA_W-1:0]    srcEvents3,
   input  wire logic [ifc_pkg::NUM_EXT-1:0]   extIn,
   input  wire logic                          maskInstrActive,
   output logic                               altTableSelect,
   output logic      [4*ifc_pkg::DATA_W-1:0]  enabledRequests
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [15:0] flags0;
   logic [15:0] flags1;
   logic [15:0] flags2;
   logic [15:0] flags3;
   logic [15:0] enable0;
   logic [15:0] enable1;
   logic [15:0] enable2;
   logic [15:0] enable3;
   logic        altTable;
   logic [ifc_pkg::NUM_EXT-1:0] extPol;
   logic        maskActive;
   logic [ifc_pkg::NUM_EXT-1:0] syncStage [SYNC_STAGES];
   logic [ifc_pkg::NUM_EXT-1:0] extPrev;
   logic [ifc_pkg::NUM_EXT-1:0] extEdge;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire wrCtrl  = ifc_pkg::OFS_CTRL   == bus.addr && bus.wrStb;
   wire wrF0    = ifc_pkg::OFS_FLAGS0 == bus.addr && bus.wrStb;
   wire wrF1    = ifc_pkg::OFS_FLAGS1 == bus.addr && bus.wrStb;
   wire wrF2    = ifc_pkg::OFS_FLAGS2 == bus.addr && bus.wrStb;
   wire wrF3    = ifc_pkg::OFS_FLAGS3 == bus.addr && bus.wrStb;
   wire wrE0    = ifc_pkg::OFS_ENABLE0 == bus.addr && bus.wrStb;
   wire wrE1    = ifc_pkg::OFS_ENABLE1 == bus.addr && bus.wrStb;
   wire wrE2    = ifc_pkg::OFS_ENABLE2 == bus.addr && bus.wrStb;
   wire wrE3    = ifc_pkg::OFS_ENABLE3 == bus.addr && bus.wrStb;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and edge detect
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            syncStage[i] <= '0;
         end
         extPrev <= '0;
      end else begin
         syncStage[0] <= extIn;
         for (int i = 1; i < SYNC_STAGES; i++) begin
            syncStage[i] <= syncStage[i-1];
         end
         extPrev <= syncStage[SYNC_STAGES-1];
      end
   end

   wire [ifc_pkg::NUM_EXT-1:0] extNow = syncStage[SYNC_STAGES-1];

   genvar g;
   generate
      for (g = 0; g < ifc_pkg::NUM_EXT; g++) begin : gEdge
         // falling when polarity set, rising otherwise
         assign extEdge[g] = extPol[g] ? (extPrev[g] && !extNow[g])
                                       : (!extPrev[g] && extNow[g]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // flag next values: set beats software clear
   wire [15:0] ext0Vec = {15'h0000, extEdge[0]} << ifc_pkg::EXT0_FLAG_BIT;
   wire [15:0] ext1Vec = 16'(extEdge[1]) << ifc_pkg::EXT1_FLAG_BIT;
   wire [15:0] ext2Vec = 16'(extEdge[2]) << ifc_pkg::EXT2_FLAG_BIT;
   wire [15:0] set0 = (srcEvents0 | ext0Vec) & ifc_pkg::FLAGS0_MASK;
   wire [15:0] set1 = (srcEvents1 | ext1Vec | ext2Vec)
                      & ifc_pkg::FLAGS1_MASK;
   wire [15:0] set2 = srcEvents2 & ifc_pkg::FLAGS2_MASK;
   wire [15:0] set3 = srcEvents3 & ifc_pkg::FLAGS3_MASK;
   wire [15:0] next_flags0 = ((wrF0 ? bus.wrData : flags0) | set0)
                             & ifc_pkg::FLAGS0_MASK;
   wire [15:0] next_flags1 = ((wrF1 ? bus.wrData : flags1) | set1)
                             & ifc_pkg::FLAGS1_MASK;
   wire [15:0] next_flags2 = ((wrF2 ? bus.wrData : flags2) | set2)
                             & ifc_pkg::FLAGS2_MASK;
   wire [15:0] next_flags3 = ((wrF3 ? bus.wrData : flags3) | set3)
                             & ifc_pkg::FLAGS3_MASK;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flags0 <= ifc_pkg::RESET_VAL;
         flags1 <= ifc_pkg::RESET_VAL;
         flags2 <= ifc_pkg::RESET_VAL;
         flags3 <= ifc_pkg::RESET_VAL;
      end else begin
         flags0 <= next_flags0;
         flags1 <= next_flags1;
         flags2 <= next_flags2;
         flags3 <= next_flags3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and enable registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         altTable   <= 1'b0;
         extPol     <= '0;
         maskActive <= 1'b0;
         enable0    <= ifc_pkg::RESET_VAL;
         enable1    <= ifc_pkg::RESET_VAL;
         enable2    <= ifc_pkg::RESET_VAL;
         enable3    <= ifc_pkg::RESET_VAL;
      end else begin
         maskActive <= maskInstrActive;
         if (wrCtrl) begin
            altTable <= bus.wrData[ifc_pkg::ALT_TABLE_BIT];
            extPol   <= bus.wrData[ifc_pkg::EXT0_POL_BIT +: ifc_pkg::NUM_EXT];
         end
         if (wrE0) begin
            enable0 <= bus.wrData & ifc_pkg::FLAGS0_MASK;
         end
         if (wrE1) begin
            enable1 <= bus.wrData & ifc_pkg::FLAGS1_MASK;
         end
         if (wrE2) begin
            enable2 <= bus.wrData & ifc_pkg::FLAGS2_MASK;
         end
         if (wrE3) begin
            enable3 <= bus.wrData & ifc_pkg::FLAGS3_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux, unmapped reads zero
   wire [15:0] ctrlView = (16'(altTable) << ifc_pkg::ALT_TABLE_BIT)
                        | (16'(maskActive) << ifc_pkg::MASK_ACTIVE_BIT)
                        | 16'(extPol);
   logic [15:0] next_rdData;
   always_comb begin
      next_rdData = 16'h0000;
      if (bus.rdStb) begin
         case (bus.addr)
            ifc_pkg::OFS_CTRL:    next_rdData = ctrlView;
            ifc_pkg::OFS_FLAGS0:  next_rdData = flags0;
            ifc_pkg::OFS_FLAGS1:  next_rdData = flags1;
            ifc_pkg::OFS_FLAGS2:  next_rdData = flags2;
            ifc_pkg::OFS_FLAGS3:  next_rdData = flags3;
            ifc_pkg::OFS_ENABLE0: next_rdData = enable0;
            ifc_pkg::OFS_ENABLE1: next_rdData = enable1;
            ifc_pkg::OFS_ENABLE2: next_rdData = enable2;
            ifc_pkg::OFS_ENABLE3: next_rdData = enable3;
            default:              next_rdData = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData          <= 16'h0000;
         altTableSelect  <= 1'b0;
         enabledRequests <= '0;
      end else begin
         rdData          <= next_rdData;
         altTableSelect  <= altTable;
         enabledRequests <= {flags3 & enable3, flags2 & enable2,
                             flags1 & enable1, flags0 & enable0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   flag_sticky_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      !wrF0 |=> (flags0 & $past(flags0)) == $past(flags0))
      else $error("flag cleared without write");
   set_wins_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrF1 && srcEvents1[15]) |=> flags1[15])
      else $error("set lost on clear");
   unused_zero_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (flags0[15:14] == 2'b00) && !flags0[4] && (flags1[8:5] == 4'h0)
      && (flags3 & ~16'h4006) == 16'h0000)
      else $error("unused flag bit set");
   ext0_edge_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      ($rose(syncStage[SYNC_STAGES-1][0]) && !extPol[0] && !wrF0)
      |=> flags0[0])
      else $error("ext0 rising edge missed");
   ext1_fall_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      ($fell(syncStage[SYNC_STAGES-1][1]) && extPol[1] && !wrF1)
      |=> flags1[4])
      else $error("ext1 falling edge missed");
   ext2_fall_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      ($fell(syncStage[SYNC_STAGES-1][2]) && extPol[2] && !wrF1)
      |=> flags1[13])
      else $error("ext2 falling edge missed");
   mask_ro_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_CTRL)
      |=> rdData[14] == $past(maskActive))
      else $error("mask status wrong");
   alt_sel_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrCtrl |=> ##1 altTableSelect == $past(bus.wrData[15], 2))
      else $error("alt table select wrong");
   uart_flag_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      srcEvents0[12] |=> flags0[12])
      else $error("uart tx flag missed");
   gate_en_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      !enable2[13] |=> !enabledRequests[45])
      else $error("disabled request passed");
   set_flags0_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (srcEvents0 & ifc_pkg::FLAGS0_MASK) != 16'h0000 |=> (flags0 & $past(srcEvents0)
      & ifc_pkg::FLAGS0_MASK) == ($past(srcEvents0) & ifc_pkg::FLAGS0_MASK))
      else $error("flags 0 event lost");
   set_flags1_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (srcEvents1 & ifc_pkg::FLAGS1_MASK) != 16'h0000 |=> (flags1 & $past(srcEvents1)
      & ifc_pkg::FLAGS1_MASK) == ($past(srcEvents1) & ifc_pkg::FLAGS1_MASK))
      else $error("flags 1 event lost");
   set_flags2_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (srcEvents2 & ifc_pkg::FLAGS2_MASK) != 16'h0000 |=> (flags2 & $past(srcEvents2)
      & ifc_pkg::FLAGS2_MASK) == ($past(srcEvents2) & ifc_pkg::FLAGS2_MASK))
      else $error("flags 2 event lost");
   set_flags3_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (srcEvents3 & ifc_pkg::FLAGS3_MASK) != 16'h0000 |=> (flags3 & $past(srcEvents3)
      & ifc_pkg::FLAGS3_MASK) == ($past(srcEvents3) & ifc_pkg::FLAGS3_MASK))
      else $error("flags 3 event lost");
   unused_flags0_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (flags0 & ~ifc_pkg::FLAGS0_MASK) == 16'h0000)
      else $error("flags 0 unused bit set");
   unused_flags1_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (flags1 & ~ifc_pkg::FLAGS1_MASK) == 16'h0000)
      else $error("flags 1 unused bit set");
   unused_flags2_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (flags2 & ~ifc_pkg::FLAGS2_MASK) == 16'h0000)
      else $error("flags 2 unused bit set");
   unused_flags3_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (flags3 & ~ifc_pkg::FLAGS3_MASK) == 16'h0000)
      else $error("flags 3 unused bit set");
   wr_flags0_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrF0 && set0 == 16'h0000)
      |=> flags0 == ($past(bus.wrData) & ifc_pkg::FLAGS0_MASK))
      else $error("flags 0 write lost");
   wr_flags1_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrF1 && set1 == 16'h0000)
      |=> flags1 == ($past(bus.wrData) & ifc_pkg::FLAGS1_MASK))
      else $error("flags 1 write lost");
   wr_flags2_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrF2 && set2 == 16'h0000)
      |=> flags2 == ($past(bus.wrData) & ifc_pkg::FLAGS2_MASK))
      else $error("flags 2 write lost");
   wr_flags3_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrF3 && set3 == 16'h0000)
      |=> flags3 == ($past(bus.wrData) & ifc_pkg::FLAGS3_MASK))
      else $error("flags 3 write lost");
   wr_enable0_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrE0 |=> enable0 == ($past(bus.wrData) & ifc_pkg::FLAGS0_MASK))
      else $error("enable 0 write wrong");
   wr_enable1_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrE1 |=> enable1 == ($past(bus.wrData) & ifc_pkg::FLAGS1_MASK))
      else $error("enable 1 write wrong");
   wr_enable2_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrE2 |=> enable2 == ($past(bus.wrData) & ifc_pkg::FLAGS2_MASK))
      else $error("enable 2 write wrong");
   wr_enable3_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrE3 |=> enable3 == ($past(bus.wrData) & ifc_pkg::FLAGS3_MASK))
      else $error("enable 3 write wrong");
   gate_req0_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=> enabledRequests[15:0] == ($past(flags0) & $past(enable0)))
      else $error("request 0 gating wrong");
   gate_req1_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=> enabledRequests[31:16] == ($past(flags1) & $past(enable1)))
      else $error("request 1 gating wrong");
   gate_req2_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=> enabledRequests[47:32] == ($past(flags2) & $past(enable2)))
      else $error("request 2 gating wrong");
   gate_req3_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=> enabledRequests[63:48] == ($past(flags3) & $past(enable3)))
      else $error("request 3 gating wrong");
   ext0_fall_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      ($fell(syncStage[SYNC_STAGES-1][0]) && extPol[0] && !wrF0)
      |=> flags0[0])
      else $error("ext0 falling edge missed");
   ext1_rise_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      ($rose(syncStage[SYNC_STAGES-1][1]) && !extPol[1] && !wrF1)
      |=> flags1[4])
      else $error("ext1 rising edge missed");
   ext2_rise_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      ($rose(syncStage[SYNC_STAGES-1][2]) && !extPol[2] && !wrF1)
      |=> flags1[13])
      else $error("ext2 rising edge missed");
   ext_once_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (extEdge != '0) |=> ((extEdge & $past(extEdge)) == '0)
      || (extPol != $past(extPol)))
      else $error("one edge detected twice");
   rd_idle_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      !bus.rdStb |=> rdData == 16'h0000)
      else $error("read data without read");
   rd_flags0_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_FLAGS0)
      |=> rdData == $past(flags0))
      else $error("flags 0 read wrong");
   rd_flags1_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_FLAGS1)
      |=> rdData == $past(flags1))
      else $error("flags 1 read wrong");
   rd_flags2_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_FLAGS2)
      |=> rdData == $past(flags2))
      else $error("flags 2 read wrong");
   rd_flags3_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_FLAGS3)
      |=> rdData == $past(flags3))
      else $error("flags 3 read wrong");
   rd_enable0_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_ENABLE0)
      |=> rdData == $past(enable0))
      else $error("enable 0 read wrong");
   rd_enable3_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_ENABLE3)
      |=> rdData == $past(enable3))
      else $error("enable 3 read wrong");
   rd_ctrl_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr == ifc_pkg::OFS_CTRL)
      |=> rdData[13:3] == 11'h000 && rdData[15] == $past(altTable)
      && rdData[2:0] == $past(extPol))
      else $error("control read wrong");
   rd_unmapped_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (bus.rdStb && bus.addr[0] && bus.addr != ifc_pkg::OFS_ENABLE3)
      |=> rdData == 16'h0000)
      else $error("unmapped read not zero");
   ctrl_pol_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrCtrl |=> extPol
      == $past(bus.wrData[ifc_pkg::EXT0_POL_BIT +: ifc_pkg::NUM_EXT]))
      else $error("polarity write lost");
   mask_follow_a : assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=> maskActive == $past(maskInstrActive))
      else $error("mask status not tracked");
endmodule

// ==== inc/ifc_pkg.sv ====
// package: register map, flag masks and field positions for the flag and edge block
package ifc_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // register offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_FLAGS0 = 4'h2;
   localparam logic [3:0] OFS_FLAGS1 = 4'h4;
   localparam logic [3:0] OFS_FLAGS2 = 4'h6;
   localparam logic [3:0] OFS_FLAGS3 = 4'h8;
   localparam logic [3:0] OFS_ENABLE0 = 4'hA;
   localparam logic [3:0] OFS_ENABLE1 = 4'hC;
   localparam logic [3:0] OFS_ENABLE2 = 4'hE;
   localparam logic [3:0] OFS_ENABLE3 = 4'h1;
   // control register fields
   localparam int ALT_TABLE_BIT   = 15;
   localparam int MASK_ACTIVE_BIT = 14;
   localparam int EXT0_POL_BIT    = 0;
   localparam int NUM_EXT         = 3;
   localparam logic [15:0] CTRL_WMASK = 16'h8007;
   localparam logic [15:0] RESET_VAL  = 16'h0000;
   // implemented flag bits per register
   localparam logic [15:0] FLAGS0_MASK = 16'h3FEF;
   localparam logic [15:0] FLAGS1_MASK = 16'hFE1F;
   localparam logic [15:0] FLAGS2_MASK = 16'h22E3;
   localparam logic [15:0] FLAGS3_MASK = 16'h4006;
   // external input flag positions
   localparam int EXT0_FLAG_BIT = 0;
   localparam int EXT1_FLAG_BIT = 4;
   localparam int EXT2_FLAG_BIT = 13;

   typedef struct packed {
      logic              wrStb;
      logic              rdStb;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
   } ifc_bus_t;
endpackage

// ==== dv/ifc_src_model.sv ====
// peripheral event sources and external pin drivers for the flag block
`timescale 1ns/1ps
module ifc_src_model (
   input  wire logic        sys_clk,
   input  wire logic [63:0] firePulse,
   input  wire logic [2:0]  pinLevel,
   output logic      [63:0] events,
   output logic      [2:0]  pins
);
   // one-cycle event pulse per request
   always_ff @(posedge sys_clk) begin
      events <= firePulse;
   end
   assign pins = pinLevel;
endmodule

// ==== dv/ifc_flag_edge_ctrl_tb.sv ====
// self-checking bench for flag registers, edge control and vector select
`timescale 1ns/1ps
module ifc_flag_edge_ctrl_tb;
   logic              sys_clk;
   logic              rst_b;
   logic              maskInstrActive;
   logic              altTableSelect;
   ifc_pkg::ifc_bus_t bus;
   logic [15:0]       rdData;
   logic [63:0]       firePulse;
   logic [63:0]       events;
   logic [63:0]       enabledRequests;
   logic [2:0]        pinLevel;
   logic [2:0]        pins;
   int                errTotal;
   int                samplesChecked;
   logic [3:0]        flagOfs [4] = '{ifc_pkg::OFS_FLAGS0, ifc_pkg::OFS_FLAGS1,
                                      ifc_pkg::OFS_FLAGS2, ifc_pkg::OFS_FLAGS3};
   logic [3:0]        enOfs [4] = '{ifc_pkg::OFS_ENABLE0, ifc_pkg::OFS_ENABLE1,
                                    ifc_pkg::OFS_ENABLE2, ifc_pkg::OFS_ENABLE3};
   logic [15:0]       flagMask [4] = '{ifc_pkg::FLAGS0_MASK, ifc_pkg::FLAGS1_MASK,
                                       ifc_pkg::FLAGS2_MASK, ifc_pkg::FLAGS3_MASK};
   ifc_flag_edge_ctrl uut (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rdData(rdData),
      .srcEvents0(events[15:0]), .srcEvents1(events[31:16]), .srcEvents2(events[47:32]),
      .srcEvents3(events[63:48]), .extIn(pins), .maskInstrActive(maskInstrActive),
      .altTableSelect(altTableSelect), .enabledRequests(enabledRequests));
   ifc_src_model src (.sys_clk(sys_clk), .firePulse(firePulse), .pinLevel(pinLevel),
      .events(events), .pins(pins));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic giveVerdict();
      if (errTotal == 0 && samplesChecked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wrData: d};
      @(posedge sys_clk);
      bus <= '0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      bus <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wrData: 16'h0000};
      @(posedge sys_clk);
      bus <= '0;
      #1;
      chk(64'(rdData), 64'(exp));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic resetValues();
      rdChk(ifc_pkg::OFS_CTRL, 16'h0000);
      for (int r = 0; r < 4; r++) rdChk(flagOfs[r], 16'h0000);
      rdChk(4'h3, 16'h0000);
   endtask
   task automatic flagReadWrite();
      for (int r = 0; r < 4; r++) begin
         wr(flagOfs[r], 16'hFFFF);
         rdChk(flagOfs[r], flagMask[r]);
         wr(flagOfs[r], 16'h0000);
         rdChk(flagOfs[r], 16'h0000);
      end
   endtask
   task automatic ctrlReg();
      wr(ifc_pkg::OFS_CTRL, 16'hFFFF);
      rdChk(ifc_pkg::OFS_CTRL, 16'h8007);
      chk(64'(altTableSelect), 64'h1);
      @(posedge sys_clk) maskInstrActive <= 1'b1;
      rdChk(ifc_pkg::OFS_CTRL, 16'hC007);
      wr(ifc_pkg::OFS_CTRL, 16'h0000);
      rdChk(ifc_pkg::OFS_CTRL, 16'h4000);
      chk(64'(altTableSelect), 64'h0);
      @(posedge sys_clk) maskInstrActive <= 1'b0;
   endtask
   task automatic srcPulses();
      @(posedge sys_clk) firePulse <= 64'hFFFF_FFFF_DFEF_FFFE;
      @(posedge sys_clk) firePulse <= '0;
      repeat (3) @(posedge sys_clk);
      rdChk(flagOfs[0], flagMask[0] & 16'hFFFE);
      rdChk(flagOfs[1], flagMask[1] & 16'hDFEF);
      rdChk(flagOfs[2], flagMask[2]);
      rdChk(flagOfs[3], flagMask[3]);
      for (int r = 0; r < 4; r++) wr(flagOfs[r], 16'h0000);
   endtask
   task automatic extEdges();
      logic [3:0]  ofs;
      logic [15:0] bitVal;
      for (int i = 0; i < 3; i++) begin
         for (int p = 0; p < 2; p++) begin
            ofs = (i == 0) ? ifc_pkg::OFS_FLAGS0 : ifc_pkg::OFS_FLAGS1;
            bitVal = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0010 : 16'h2000;
            @(posedge sys_clk) pinLevel[i] <= ~p[0];
            wr(ifc_pkg::OFS_CTRL, 16'(p) << i);
            repeat (6) @(posedge sys_clk);
            wr(ifc_pkg::OFS_FLAGS0, 16'h0000);
            wr(ifc_pkg::OFS_FLAGS1, 16'h0000);
            @(posedge sys_clk) pinLevel[i] <= p[0];
            repeat (5) @(posedge sys_clk);
            rdChk(ofs, 16'h0000);
            @(posedge sys_clk) pinLevel[i] <= ~p[0];
            repeat (5) @(posedge sys_clk);
            rdChk(ofs, bitVal);
            wr(ofs, 16'h0000);
            repeat (5) @(posedge sys_clk);
            rdChk(ofs, 16'h0000);
         end
      end
   endtask
   task automatic enableGate();
      wr(ifc_pkg::OFS_ENABLE0, 16'hFFFF);
      wr(ifc_pkg::OFS_FLAGS0, 16'hFFFF);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(enabledRequests, {48'h0, ifc_pkg::FLAGS0_MASK});
      wr(ifc_pkg::OFS_ENABLE0, 16'h0000);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(enabledRequests, 64'h0);
      wr(ifc_pkg::OFS_FLAGS0, 16'h0000);
      for (int r = 0; r < 4; r++) begin
         wr(enOfs[r], 16'hFFFF);
         rdChk(enOfs[r], flagMask[r]);
         wr(enOfs[r], 16'h0000);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      errTotal++;
      giveVerdict();
   end
   initial begin
      rst_b = 1'b0;
      bus = '0;
      firePulse = '0;
      pinLevel = '0;
      maskInstrActive = 1'b0;
      errTotal = 0;
      samplesChecked = 0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      resetValues();
      flagReadWrite();
      ctrlReg();
      srcPulses();
      extEdges();
      enableGate();
      giveVerdict();
   end
endmodule
